// File: dfts_cfg.svh
`ifndef DFTS_CFG_SVH
`define DFTS_CFG_SVH
// ==========================================================
// Register port and byte offsets
`define DFTS_AW        8
`define DFTS_DW        32
`define DFTS_MW        16
`define DFTS_A_CTRL    8'h00
`define DFTS_A_PSEL    8'h04
`define DFTS_A_LLVL    8'h08
`define DFTS_A_RATE    8'h0C
`define DFTS_A_GND     8'h10
`define DFTS_A_MFF     8'h14
`define DFTS_A_TRIP    8'h18
`define DFTS_A_LVST    8'h1C
// ==========================================================
// Reset values and fields
`define DFTS_PSEL_RST  32'h0000_0000
`define DFTS_LLVL_RST  32'h001E_0096
`define DFTS_RATE_RST  32'h000F_0064
`define DFTS_GND_RST   16'hFFFF
`define DFTS_MFF_RST   32'h0000_0000
`define DFTS_F_RST     0
`define DFTS_PS_OVL    7:0
`define DFTS_PS_UNL    15:8
`define DFTS_PS_MTH    23:16
`define DFTS_PS_PHL    31:24
`define DFTS_PL_OUT    1
`define DFTS_PL_IN     2
`define DFTS_LO_HALF   15:0
`define DFTS_HI_HALF   31:16
`define DFTS_ST_DIAG   12:8
`define DFTS_ST_FATAL  16
`define DFTS_KW_LIMIT  16'h001E
`define DFTS_FN_EXT    4'h3
`define DFTS_FN_BLK    4'h4
`define DFTS_FN_W      4
// ==========================================================
// Indication indices
`define DFTS_T_OVL     0
`define DFTS_T_UNL     1
`define DFTS_T_OC1     2
`define DFTS_T_OVV     3
`define DFTS_T_UV2     4
`define DFTS_T_GND     5
`define DFTS_T_MTH     6
`define DFTS_T_OPH     7
`define DFTS_T_IPH     8
`define DFTS_T_OLT     9
`define DFTS_T_SAFE    10
`define DFTS_T_FUSE    11
`define DFTS_T_OHT     12
`define DFTS_T_OC2     13
`define DFTS_T_EXT     14
`define DFTS_NTRIP     15
`define DFTS_L_UV      0
`define DFTS_L_BLK     1
`define DFTS_NLVL      2
`define DFTS_D_MEM     0
`define DFTS_NDIAG     5
// ==========================================================
// Timing
`define DFTS_CLK_MHZ    200
`define DFTS_TICK_US    1000
`define DFTS_TICK_W     18
`define DFTS_ACC_W      17
`define DFTS_MS_PER_SEC 1000
`define DFTS_MS_PER_MIN 60000
`define DFTS_OLT_NOM_PCT 16'h0064
`define DFTS_OLT_LO_PCT 16'h0096
`define DFTS_OLT_HI_PCT 16'h00C8
`define DFTS_OLT_LO_MIN 1
`define DFTS_OLT_HI_SEC 4
`endif

// File: dfts_pkg.sv
`default_nettype none
`include "dfts_cfg.svh"
package dfts_pkg;
  // ==========================================================
  // Types
  typedef logic [`DFTS_DW-1:0]     dfts_word_t;
  typedef logic [`DFTS_ACC_W-1:0]  dfts_acc_t;
  typedef logic [`DFTS_TICK_W-1:0] dfts_tick_t;
  typedef struct packed {
    logic [`DFTS_NTRIP-1:0] trip;
    logic [`DFTS_NLVL-1:0]  lvl;
    logic [`DFTS_NDIAG-1:0] diag;
    logic                   fatal;
    logic                   inhibit;
    logic                   rst_pulse;
    dfts_word_t             psel;
    dfts_word_t             llvl;
    dfts_word_t             rate;
    dfts_word_t             mff;
    logic [`DFTS_MW-1:0]    gnd_thr;
    dfts_word_t             rdata;
    dfts_tick_t             tick_cnt;
  } dfts_state_t;
  typedef struct packed {
    dfts_acc_t acc;
    logic      trip;
  } dfts_th_state_t;
  typedef struct packed {
    logic ext;
    logic blk;
  } dfts_mf_state_t;
  localparam dfts_state_t DFTS_STATE_RST = '{trip: '0, lvl: '0, diag: '0, fatal: 1'b0, inhibit: 1'b0,
    rst_pulse: 1'b0, psel: `DFTS_PSEL_RST, llvl: `DFTS_LLVL_RST, rate: `DFTS_RATE_RST,
    mff: `DFTS_MFF_RST, gnd_thr: `DFTS_GND_RST, rdata: '0, tick_cnt: '0};
endpackage
`default_nettype wire

// File: dfts_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "dfts_cfg.svh"
// ==========================================================
// Thermal model link
interface dfts_th_if;
  logic                tick;
  logic                en;
  logic [`DFTS_MW-1:0] load_pct;
  logic                trip;
  modport th  (input tick, en, load_pct, output trip);
  modport sup (output tick, en, load_pct, input trip);
endinterface
// ==========================================================
// Multi-function input link
interface dfts_mf_if #(parameter int N = 8);
  logic [N-1:0]            mf_in;
  logic [N*`DFTS_FN_W-1:0] func;
  logic                    ext;
  logic                    blk;
  modport mf  (input mf_in, func, output ext, blk);
  modport sup (output mf_in, func, input ext, blk);
endinterface
`default_nettype wire

// File: dfts_thermal.sv
`timescale 1ns/1ps
`default_nettype none
module dfts_thermal
  import dfts_pkg::*;
#(
  parameter int LIMIT_MS = `DFTS_OLT_LO_MIN * `DFTS_MS_PER_MIN,
  parameter int RATE_HI  = LIMIT_MS / (`DFTS_OLT_HI_SEC * `DFTS_MS_PER_SEC)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Supervisor side
  dfts_th_if.th    th
);
  localparam dfts_acc_t LIMIT = dfts_acc_t'(LIMIT_MS);
  localparam dfts_acc_t HI    = dfts_acc_t'(RATE_HI);
  dfts_th_state_t s_q;
  dfts_th_state_t s_d;
  // ==========================================================
  // Inverse-time accumulator, one step per millisecond tick
  always_comb begin
    s_d = s_q;
    if (!th.en) begin
      s_d.acc = '0;
    end else if (th.tick) begin
      if (th.load_pct >= `DFTS_OLT_HI_PCT) begin
        s_d.acc = (s_q.acc >= LIMIT - HI) ? LIMIT : s_q.acc + HI;
      end else if (th.load_pct >= `DFTS_OLT_LO_PCT) begin
        s_d.acc = (s_q.acc >= LIMIT) ? LIMIT : s_q.acc + 1'b1;
      end else if (th.load_pct < `DFTS_OLT_NOM_PCT && s_q.acc != '0) begin
        s_d.acc = s_q.acc - 1'b1;
      end
    end
    s_d.trip = th.en && (s_q.acc >= LIMIT);
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign th.trip = s_q.trip;
  th_trip_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    th.en && s_q.acc >= LIMIT |=> th.trip) else $error("thermal limit reached without trip");
  th_fast_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    th.en && th.tick && th.load_pct >= `DFTS_OLT_HI_PCT && s_q.acc < LIMIT - HI
    |=> s_q.acc == $past(s_q.acc) + HI) else $error("fast overload rate wrong");
endmodule  // dfts_thermal
`default_nettype wire

// File: dfts_mfin.sv
`timescale 1ns/1ps
`default_nettype none
module dfts_mfin
  import dfts_pkg::*;
#(
  parameter int N = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Supervisor side
  dfts_mf_if.mf    mf
);
  dfts_mf_state_t s_q;
  dfts_mf_state_t s_d;
  logic [N-1:0]   hit_ext;
  logic [N-1:0]   hit_blk;
  // ==========================================================
  // Per-input function decode
  for (genvar i = 0; i < N; i++) begin : g_in
    assign hit_ext[i] = mf.mf_in[i] && (mf.func[i*`DFTS_FN_W +: `DFTS_FN_W] == `DFTS_FN_EXT);
    assign hit_blk[i] = mf.mf_in[i] && (mf.func[i*`DFTS_FN_W +: `DFTS_FN_W] == `DFTS_FN_BLK);
  end
  always_comb begin
    s_d     = s_q;
    s_d.ext = |hit_ext;
    s_d.blk = |hit_blk;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign mf.ext = s_q.ext;
  assign mf.blk = s_q.blk;
  mf_blk_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    1'b1 |=> mf.blk == $past(|hit_blk)) else $error("block input not followed");
endmodule  // dfts_mfin
`default_nettype wire

// File: dfts_supervisor.sv
// How it works
// - Overload trip latches when selection nonzero
// - Underload trip latches when selection nonzero and running
// - Current above twice rating latches trip
// - DC bus overvoltage latches trip
// - Undervoltage is level; latched while running
// - Ground current over threshold latches trip
// - Motor thermal model trips when selected
// - Open output phase trips when bit1 set
// - Open input phase trips when bit2 set
// - Drive overload: 150% minute, 200% four seconds
// - Safety block latches safety error
// - Fuse overcurrent trips above 30 kW only
// - Heat-sink overtemperature latches trip
// - DC short-circuit detector latches second overcurrent
// - Function-3 input latches external trip
// - Function-4 input blocks output, level only
// - Memory, converter, watchdog errors are fatal
// - Parameter memory error is its own subtype
// - Gate supply loss subtype from 30 kW
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dfts_supervisor
  import dfts_pkg::*;
#(
  parameter int N_MF         = 8,
  parameter int TICK_CYC     = `DFTS_TICK_US * `DFTS_CLK_MHZ,
  parameter int OLT_LIMIT_MS = `DFTS_OLT_LO_MIN * `DFTS_MS_PER_MIN,
  parameter int OLT_RATE_HI  = OLT_LIMIT_MS / (`DFTS_OLT_HI_SEC * `DFTS_MS_PER_SEC),
  parameter int MTH_LIMIT_MS = OLT_LIMIT_MS,
  parameter int MTH_RATE_HI  = OLT_RATE_HI
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  // Register port
  input  wire logic [`DFTS_AW-1:0]    reg_addr,
  input  wire logic [`DFTS_DW-1:0]    reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`DFTS_DW-1:0]    reg_rdata,
  // Measurements
  input  wire logic [`DFTS_MW-1:0]    out_current,
  input  wire logic [`DFTS_MW-1:0]    load_pct,
  input  wire logic [`DFTS_MW-1:0]    gnd_current,
  // Comparator and status flags
  input  wire logic                   drive_running,
  input  wire logic                   dc_over_volt,
  input  wire logic                   dc_under_volt,
  input  wire logic [2:0]             out_phase_open,
  input  wire logic [2:0]             in_phase_open,
  input  wire logic                   safety_block,
  input  wire logic                   dc_fuse_overcurrent,
  input  wire logic                   heatsink_over_temp,
  input  wire logic                   dc_short_circuit,
  input  wire logic [N_MF-1:0]        mf_in,
  // Hardware diagnostics
  input  wire logic                   param_memory_error,
  input  wire logic                   adc_offset_error,
  input  wire logic                   watchdog_1,
  input  wire logic                   watchdog_2,
  input  wire logic                   gate_supply_loss,
  // Indications
  output logic      [`DFTS_NTRIP-1:0] trip_latched,
  output logic      [`DFTS_NLVL-1:0]  level_ind,
  output logic      [`DFTS_NDIAG-1:0] diag_fault,
  output logic                        fatal_fault,
  output logic                        output_inhibit
);
  localparam dfts_tick_t TICK_LAST = dfts_tick_t'(TICK_CYC - 1);

  dfts_state_t            s_q;
  dfts_state_t            s_d;
  logic [`DFTS_NTRIP-1:0] cause;
  logic [`DFTS_NDIAG-1:0] diag_cause;
  logic [7:0]             ovl_sel;
  logic [7:0]             unl_sel;
  logic [7:0]             mth_sel;
  logic [7:0]             phase_loss_enable_bits;
  logic [`DFTS_MW-1:0]    ovl_lvl;
  logic [`DFTS_MW-1:0]    unl_lvl;
  logic [`DFTS_MW-1:0]    rated_cur;
  logic [`DFTS_MW-1:0]    power_kw;
  logic                   tick;
  logic                   mth_on;

  // ==========================================================
  // Configuration fields
  assign ovl_sel                = s_q.psel[`DFTS_PS_OVL];
  assign unl_sel                = s_q.psel[`DFTS_PS_UNL];
  assign mth_sel                = s_q.psel[`DFTS_PS_MTH];
  assign phase_loss_enable_bits = s_q.psel[`DFTS_PS_PHL];
  assign ovl_lvl                = s_q.llvl[`DFTS_LO_HALF];
  assign unl_lvl                = s_q.llvl[`DFTS_HI_HALF];
  assign rated_cur              = s_q.rate[`DFTS_LO_HALF];
  assign power_kw               = s_q.rate[`DFTS_HI_HALF];
  assign tick                   = (s_q.tick_cnt == TICK_LAST);
  assign mth_on                 = (mth_sel != '0);

  // ==========================================================
  // Thermal models and input decode
  dfts_th_if olt_bus ();
  dfts_th_if mth_bus ();
  dfts_mf_if #(.N(N_MF)) mf_bus ();

  assign olt_bus.tick     = tick;
  assign olt_bus.en       = 1'b1;
  assign olt_bus.load_pct = load_pct;
  assign mth_bus.tick     = tick;
  assign mth_bus.en       = mth_on;
  assign mth_bus.load_pct = load_pct;
  assign mf_bus.mf_in     = mf_in;
  assign mf_bus.func      = s_q.mff[N_MF*`DFTS_FN_W-1:0];

  dfts_thermal #(
    .LIMIT_MS (OLT_LIMIT_MS),
    .RATE_HI  (OLT_RATE_HI)
  ) u_olt (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .th      (olt_bus.th)
  );

  dfts_thermal #(
    .LIMIT_MS (MTH_LIMIT_MS),
    .RATE_HI  (MTH_RATE_HI)
  ) u_mth (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .th      (mth_bus.th)
  );

  dfts_mfin #(
    .N (N_MF)
  ) u_mfin (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .mf      (mf_bus.mf)
  );

  // ==========================================================
  // Trip causes
  // Underload is only judged while running, since a stopped drive always reads no load
  assign cause[`DFTS_T_OVL]  = (ovl_sel != '0) && (load_pct > ovl_lvl);
  assign cause[`DFTS_T_UNL]  = (unl_sel != '0) && drive_running && (load_pct < unl_lvl);
  assign cause[`DFTS_T_OC1]  = {1'b0, out_current} > {rated_cur, 1'b0};
  assign cause[`DFTS_T_OVV]  = dc_over_volt;
  assign cause[`DFTS_T_UV2]  = dc_under_volt && drive_running;
  assign cause[`DFTS_T_GND]  = gnd_current > s_q.gnd_thr;
  assign cause[`DFTS_T_MTH]  = mth_bus.trip;
  assign cause[`DFTS_T_OPH]  = phase_loss_enable_bits[`DFTS_PL_OUT] && (|out_phase_open);
  assign cause[`DFTS_T_IPH]  = phase_loss_enable_bits[`DFTS_PL_IN] && (|in_phase_open);
  assign cause[`DFTS_T_OLT]  = olt_bus.trip;
  assign cause[`DFTS_T_SAFE] = safety_block;
  assign cause[`DFTS_T_FUSE] = dc_fuse_overcurrent && (power_kw > `DFTS_KW_LIMIT);
  assign cause[`DFTS_T_OHT]  = heatsink_over_temp;
  assign cause[`DFTS_T_OC2]  = dc_short_circuit;
  assign cause[`DFTS_T_EXT]  = mf_bus.ext;

  // Subtype order: gate supply, watchdog 2, watchdog 1, converter offset, memory
  assign diag_cause = {gate_supply_loss && (power_kw >= `DFTS_KW_LIMIT),
                       watchdog_2, watchdog_1, adc_offset_error,
                       param_memory_error};

  // ==========================================================
  // Next state
  always_comb begin
    s_d           = s_q;
    s_d.rst_pulse = 1'b0;
    s_d.rdata     = '0;
    s_d.tick_cnt  = tick ? '0 : s_q.tick_cnt + 1'b1;
    if (reg_wr) begin
      unique case (reg_addr)
        `DFTS_A_CTRL: s_d.rst_pulse = reg_wdata[`DFTS_F_RST];
        `DFTS_A_PSEL: s_d.psel = reg_wdata;
        `DFTS_A_LLVL: s_d.llvl = reg_wdata;
        `DFTS_A_RATE: s_d.rate = reg_wdata;
        `DFTS_A_GND:  s_d.gnd_thr = reg_wdata[`DFTS_LO_HALF];
        `DFTS_A_MFF:  s_d.mff = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `DFTS_A_PSEL: s_d.rdata = s_q.psel;
        `DFTS_A_LLVL: s_d.rdata = s_q.llvl;
        `DFTS_A_RATE: s_d.rdata = s_q.rate;
        `DFTS_A_GND:  s_d.rdata = dfts_word_t'(s_q.gnd_thr);
        `DFTS_A_MFF:  s_d.rdata = s_q.mff;
        `DFTS_A_TRIP: s_d.rdata = dfts_word_t'(s_q.trip);
        `DFTS_A_LVST: begin
          s_d.rdata[`DFTS_NLVL-1:0]  = s_q.lvl;
          s_d.rdata[`DFTS_ST_DIAG]   = s_q.diag;
          s_d.rdata[`DFTS_ST_FATAL]  = s_q.fatal;
        end
        default: s_d.rdata = '0;
      endcase
    end
    // A new cause wins over a reset in the same cycle, so no event is lost
    s_d.trip = cause | (s_q.trip & ~{`DFTS_NTRIP{s_q.rst_pulse}});
    s_d.lvl[`DFTS_L_UV]  = dc_under_volt;
    s_d.lvl[`DFTS_L_BLK] = mf_bus.blk;
    // Fatal faults are only left by a power-on reset
    s_d.diag  = s_q.diag | diag_cause;
    s_d.fatal = s_q.fatal | (|diag_cause);
    s_d.inhibit = (|s_d.trip) || s_d.fatal || s_d.lvl[`DFTS_L_BLK];
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= DFTS_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata      = s_q.rdata;
  assign trip_latched   = s_q.trip;
  assign level_ind      = s_q.lvl;
  assign diag_fault     = s_q.diag;
  assign fatal_fault    = s_q.fatal;
  assign output_inhibit = s_q.inhibit;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_rst_write;
    reg_wr && reg_addr == `DFTS_A_CTRL && reg_wdata[`DFTS_F_RST];
  endsequence
  sequence s_oc1_gone;
    !cause[`DFTS_T_OC1];
  endsequence

  latch_clear_a: assert property (s_rst_write ##1 s_oc1_gone |=> !trip_latched[`DFTS_T_OC1])
    else $error("fault reset did not clear a cleared trip");
  latch_hold_a: assert property (!s_q.rst_pulse |=>
    (trip_latched & $past(trip_latched)) == $past(trip_latched))
    else $error("latched trip dropped without reset");
  fatal_hold_a: assert property ((fatal_fault and s_rst_write) |=> ##1 fatal_fault)
    else $error("fatal fault cleared by fault reset");
  ovl_gate_a: assert property (ovl_sel == '0 && !trip_latched[`DFTS_T_OVL]
    |=> !trip_latched[`DFTS_T_OVL]) else $error("overload trip while deselected");
  unl_trip_a: assert property (unl_sel != '0 && drive_running && load_pct < unl_lvl
    |=> trip_latched[`DFTS_T_UNL]) else $error("underload trip missing");
  oc1_trip_a: assert property ({1'b0, out_current} > {rated_cur, 1'b0}
    |=> trip_latched[`DFTS_T_OC1] && output_inhibit) else $error("overcurrent trip missing");
  ovv_trip_a: assert property (dc_over_volt |=> trip_latched[`DFTS_T_OVV])
    else $error("overvoltage trip missing");
  uv_level_a: assert property (1'b1 |=> level_ind[`DFTS_L_UV] == $past(dc_under_volt))
    else $error("undervoltage level does not follow input");
  uv_run_a: assert property (dc_under_volt && drive_running |=> trip_latched[`DFTS_T_UV2])
    else $error("running undervoltage not latched");
  gnd_trip_a: assert property (gnd_current > s_q.gnd_thr |=> trip_latched[`DFTS_T_GND])
    else $error("ground trip missing");
  mth_gate_a: assert property ($rose(trip_latched[`DFTS_T_MTH]) |-> $past(mth_on, 2))
    else $error("motor thermal trip while deselected");
  oph_gate_a: assert property ($rose(trip_latched[`DFTS_T_OPH])
    |-> $past(phase_loss_enable_bits[`DFTS_PL_OUT] && (|out_phase_open)))
    else $error("output phase trip without cause");
  iph_gate_a: assert property ($rose(trip_latched[`DFTS_T_IPH])
    |-> $past(phase_loss_enable_bits[`DFTS_PL_IN] && (|in_phase_open)))
    else $error("input phase trip without cause");
  olt_path_a: assert property (olt_bus.trip |=> trip_latched[`DFTS_T_OLT])
    else $error("drive overload not latched");
  safe_trip_a: assert property (safety_block |=> trip_latched[`DFTS_T_SAFE] && output_inhibit)
    else $error("safety block not latched");
  fuse_kw_a: assert property ($rose(trip_latched[`DFTS_T_FUSE]) |-> $past(power_kw > `DFTS_KW_LIMIT))
    else $error("fuse trip on small rating");
  oht_trip_a: assert property (heatsink_over_temp |=> trip_latched[`DFTS_T_OHT])
    else $error("overheat trip missing");
  oc2_trip_a: assert property (dc_short_circuit |=> trip_latched[`DFTS_T_OC2])
    else $error("short circuit trip missing");
  ext_trip_a: assert property (mf_bus.ext |=> trip_latched[`DFTS_T_EXT])
    else $error("external trip missing");
  blk_level_a: assert property (1'b1 |=> level_ind[`DFTS_L_BLK] == $past(mf_bus.blk))
    else $error("block level does not follow input");
  diag_fatal_a: assert property (watchdog_1 || watchdog_2 || adc_offset_error |=> fatal_fault)
    else $error("diagnostic not fatal");
  mem_sub_a: assert property (param_memory_error |=> diag_fault[`DFTS_D_MEM] && fatal_fault)
    else $error("memory error subtype missing");
  gate_kw_a: assert property (gate_supply_loss && power_kw >= `DFTS_KW_LIMIT
    |=> diag_fault[`DFTS_NDIAG-1]) else $error("gate supply subtype missing");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data outside its cycle");
endmodule  // dfts_supervisor
`default_nettype wire

// File: dfts_sense_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Comparator bank: each cause reaches its flag one clock late
module dfts_sense_model (
  // Clock and causes
  input  wire logic       clk_sys,
  input  wire logic [5:0] cause,
  // Flags toward the supervisor
  output logic            dc_over_volt,
  output logic            dc_under_volt,
  output logic            safety_block,
  output logic            dc_fuse_overcurrent,
  output logic            heatsink_over_temp,
  output logic            dc_short_circuit
);
  // Registered so that no flag changes in the supervisor's sampling step
  always_ff @(posedge clk_sys) begin
    {dc_short_circuit, heatsink_over_temp, dc_fuse_overcurrent} <= cause[5:3];
    {safety_block, dc_under_volt, dc_over_volt}                 <= cause[2:0];
  end
endmodule // dfts_sense_model
`default_nettype wire

// File: drive_fault_trip_supervisor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dfts_cfg.svh"
module drive_fault_trip_supervisor_tb_top;
  import dfts_pkg::*;
  // ==========================================================
  // Signals
  logic        clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, drive_running = 1'b0;
  logic [7:0]  reg_addr = '0, mf_in = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [15:0] out_current = '0, load_pct = '0, gnd_current = '0;
  logic [5:0]  cause = '0;
  logic [4:0]  hw_err = '0, diag_fault;
  logic [2:0]  out_phase_open = '0, in_phase_open = '0;
  logic [14:0] trip_latched;
  logic [1:0]  level_ind;
  logic        dc_over_volt, dc_under_volt, safety_block, dc_fuse_overcurrent, heatsink_over_temp;
  logic        dc_short_circuit, fatal_fault, output_inhibit;
  int          n_fail = 0, checks_done = 0;
  always #2.5 clk_sys = ~clk_sys;
  dfts_sense_model i_sense (.clk_sys, .cause, .dc_over_volt, .dc_under_volt, .safety_block,
    .dc_fuse_overcurrent, .heatsink_over_temp, .dc_short_circuit);
  // Short tick and limits keep the overload model within a few hundred cycles
  dfts_supervisor #(.TICK_CYC(4), .OLT_LIMIT_MS(30), .OLT_RATE_HI(15)) i_dut (.clk_sys, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .out_current, .load_pct, .gnd_current,
    .drive_running, .dc_over_volt, .dc_under_volt, .out_phase_open, .in_phase_open, .safety_block,
    .dc_fuse_overcurrent, .heatsink_over_temp, .dc_short_circuit, .mf_in, .param_memory_error(hw_err[0]),
    .adc_offset_error(hw_err[1]), .watchdog_1(hw_err[2]), .watchdog_2(hw_err[3]),
    .gate_supply_loss(hw_err[4]), .trip_latched, .level_ind, .diag_fault, .fatal_fault, .output_inhibit);
  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk_sys) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge clk_sys) reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic frst;
    wr(`DFTS_A_CTRL, 32'h0000_0001);
    settle(3);
  endtask
  task automatic cause_set(input logic [5:0] c);
    @(posedge clk_sys) cause <= c;
    settle(3);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd(`DFTS_A_PSEL, `DFTS_PSEL_RST);
    rd(`DFTS_A_LLVL, `DFTS_LLVL_RST);
    rd(`DFTS_A_GND, {16'h0000, `DFTS_GND_RST});
    wr(`DFTS_A_TRIP, 32'hFFFF_FFFF);
    rd(`DFTS_A_TRIP, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    $display("test regs done");
  endtask
  task automatic t_ovv;
    cause_set(6'h01);
    chk(32'(trip_latched), 32'h0000_0008);
    chk(32'(output_inhibit), 32'h0000_0001);
    frst;
    chk(32'(trip_latched), 32'h0000_0008);
    cause_set(6'h00);
    frst;
    chk({16'h0000, output_inhibit, trip_latched}, 32'h0000_0000);
    $display("test overvoltage done");
  endtask
  task automatic t_flags;
    logic [31:0] exp [4];
    exp = '{32'h0000_0400, 32'h0000_0000, 32'h0000_1000, 32'h0000_2000};
    for (int i = 0; i < 4; i++) begin
      cause_set(6'(4 << i));
      chk(32'(trip_latched), exp[i]);
      cause_set(6'h00);
      frst;
    end
    wr(`DFTS_A_RATE, 32'h001F_0064);
    cause_set(6'h08);
    chk(32'(trip_latched), 32'h0000_0800);
    cause_set(6'h00);
    frst;
    $display("test flags done");
  endtask
  task automatic t_load;
    @(posedge clk_sys) out_current <= 16'h00C8;
    settle(3);
    chk(32'(trip_latched), 32'h0000_0000);
    @(posedge clk_sys) out_current <= 16'h00C9;
    settle(3);
    chk(32'(trip_latched), 32'h0000_0004);
    @(posedge clk_sys) begin out_current <= 16'h0000; load_pct <= 16'h00C8; end
    settle(3);
    chk(32'(trip_latched[0]), 32'h0000_0000);
    wr(`DFTS_A_PSEL, 32'h0000_0001);
    settle(2);
    chk(32'(trip_latched[0]), 32'h0000_0001);
    settle(20);
    chk(32'(trip_latched[9]), 32'h0000_0001);
    @(posedge clk_sys) load_pct <= 16'h0000;
    wr(`DFTS_A_PSEL, 32'h0000_0000);
    settle(400);
    frst;
    chk(32'(trip_latched), 32'h0000_0000);
    $display("test load done");
  endtask
  task automatic t_phase;
    @(posedge clk_sys) begin out_phase_open <= 3'h4; in_phase_open <= 3'h1; gnd_current <= 16'h0010; end
    settle(3);
    chk(32'(trip_latched), 32'h0000_0000);
    wr(`DFTS_A_PSEL, 32'h0600_0000);
    wr(`DFTS_A_GND, 32'h0000_000F);
    settle(2);
    chk(32'(trip_latched), 32'h0000_01A0);
    @(posedge clk_sys) begin out_phase_open <= 3'h0; in_phase_open <= 3'h0; gnd_current <= 16'h0000; end
    wr(`DFTS_A_PSEL, 32'h0000_0000);
    frst;
    chk(32'(trip_latched), 32'h0000_0000);
    $display("test phase and ground done");
  endtask
  task automatic t_uv_mf;
    cause_set(6'h02);
    chk({15'h0000, level_ind, trip_latched}, 32'h0000_8000);
    @(posedge clk_sys) drive_running <= 1'b1;
    settle(3);
    chk(32'(trip_latched), 32'h0000_0010);
    @(posedge clk_sys) drive_running <= 1'b0;
    cause_set(6'h00);
    chk(32'(level_ind), 32'h0000_0000);
    frst;
    wr(`DFTS_A_MFF, 32'h0000_0043);
    @(posedge clk_sys) mf_in <= 8'h01;
    settle(4);
    chk(32'(trip_latched), 32'h0000_4000);
    @(posedge clk_sys) mf_in <= 8'h02;
    settle(4);
    frst;
    chk({14'h0000, output_inhibit, level_ind, trip_latched}, 32'h0003_0000);
    @(posedge clk_sys) mf_in <= 8'h00;
    settle(4);
    chk(32'(output_inhibit), 32'h0000_0000);
    $display("test undervoltage and inputs done");
  endtask
  task automatic t_diag;
    @(posedge clk_sys) hw_err <= 5'h01;
    @(posedge clk_sys) hw_err <= 5'h08;
    @(posedge clk_sys) hw_err <= 5'h00;
    frst;
    chk({26'h0, fatal_fault, diag_fault}, 32'h0000_0029);
    $display("test diagnostics done");
  endtask
  // ==========================================================
  // Run and verdict
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_ovv;
    t_flags;
    t_load;
    t_phase;
    t_uv_mf;
    t_diag;
    give_verdict;
  end
  initial begin
    #50000;
    n_fail++;
    give_verdict;
  end
endmodule // drive_fault_trip_supervisor_tb_top
`default_nettype wire
